// >>> inc/gflm_params.svh
// Constants for the global fault and livelock monitor
`ifndef GFLM_PARAMS_SVH
`define GFLM_PARAMS_SVH
// ==========================================================================
// Structure
`define GFLM_NUM_UNITS    12
`define GFLM_LOC_W        8
`define GFLM_CNT_W        4
`define GFLM_U_MEM        1
`define GFLM_U_CACHE      2
`define GFLM_U_CORE       3
`define GFLM_U_ACC0       4
`define GFLM_U_IO         0
// ==========================================================================
// Register byte offsets
`define GFLM_OFF_HALT     12'h000
`define GFLM_OFF_REC      12'h004
`define GFLM_OFF_ATT      12'h008
`define GFLM_OFF_MODE     12'h00c
`define GFLM_OFF_UNMASK   12'h010
`define GFLM_OFF_OVF      12'h014
`define GFLM_OFF_SERIAL   12'h018
`define GFLM_OFF_LLCFG    12'h01c
`define GFLM_OFF_SYSERR   12'h020
`define GFLM_UNIT_PAGE    4'h1
// ==========================================================================
// Field positions
`define GFLM_HALT_OVF_BIT 12
`define GFLM_HALT_REQ_BIT 28
`define GFLM_UM_HALTREQ   14
`define GFLM_UM_REC_BASE  16
`define GFLM_UM_MCHK      31
`define GFLM_MODE_RFRZ    19
`define GFLM_MODE_ACCH    26
`define GFLM_MODE_OVFH    27
`define GFLM_ATT_MCHK     31
`define GFLM_SS_LL_A      0
`define GFLM_SS_LL_B      7
`define GFLM_SS_RESAMPLE  4
`define GFLM_SS_QFLOW     16
`define GFLM_SS_QMAIN     17
`define GFLM_SS_THROTTLE  18
`define GFLM_SS_RESOLVE   19
`define GFLM_CFG_CMCHK    8
`define GFLM_CACHE_MCHK   6
// ==========================================================================
// Reset values
`define GFLM_RST_WORD     32'h0000_0000
`define GFLM_RST_BYTE     8'h00
`endif

// >>> inc/gflm_pkg.sv
// Types for the global fault and livelock monitor
package gflm_pkg;
	// Livelock tracking states
	typedef enum logic [1:0] {
		GFLM_LL_IDLE     = 2'b00,
		GFLM_LL_DETECTED = 2'b01,
		GFLM_LL_RESAMPLE = 2'b10
	} gflm_ll_e;
	typedef logic [31:0] gflm_word_t;
endpackage

// >>> rtl/gflm_unit_fault.sv
// One local unit: sticky fault bits, halt and recoverable summaries, counter
`timescale 1ns/100ps
`include "gflm_params.svh"
module gflm_unit_fault #(
	parameter bit HAS_CNT = 1'b0
) (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic [`GFLM_LOC_W-1:0] err_in,
	input  wire logic                   clr_we,
	input  wire logic [`GFLM_LOC_W-1:0] clr_mask,
	input  wire logic                   stopped,
	input  wire logic [`GFLM_LOC_W-1:0] halt_sel,
	input  wire logic [`GFLM_LOC_W-1:0] lmask,
	output logic      [`GFLM_LOC_W-1:0] fault_r,
	output logic                        halt_sum,
	output logic                        rec_sum,
	output logic                        ovf_evt
);
	logic [`GFLM_LOC_W-1:0] fault_nxt;
	logic [`GFLM_CNT_W-1:0] cnt_r;
	logic                   rec_new;

	// ======================================================================
	// Sticky fault bits
	// sticky, clear only while running
	always_comb begin
		fault_nxt = fault_r;
		if (!stopped) begin
			if (clr_we)
				fault_nxt = fault_r & ~clr_mask;
			fault_nxt = fault_nxt | err_in; // New error wins over clear
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fault_r <= `GFLM_RST_BYTE;
		else
			fault_r <= fault_nxt;
	end

	assign halt_sum = |(fault_r & ~lmask & halt_sel);
	assign rec_sum  = |(fault_r & ~lmask & ~halt_sel);
	assign rec_new  = |(err_in & ~fault_r & ~lmask & ~halt_sel) & ~stopped;

	// ======================================================================
	// Recoverable error counter
	// count recoverable errors, flag overflow
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_r <= '0;
		else if (HAS_CNT && rec_new)
			cnt_r <= cnt_r + 1'b1;
	end

	assign ovf_evt = HAS_CNT && rec_new && (&cnt_r);
endmodule

// >>> rtl/gflm_top.sv
// Global fault aggregation and livelock monitor with APB registers
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/100ps
`include "gflm_params.svh"
module gflm_top
	import gflm_pkg::*;
(
	input  wire logic                                pclk,
	input  wire logic                                presetn,
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [11:0]                         paddr,
	input  wire logic [31:0]                         pwdata,
	output logic      [31:0]                         prdata,
	output logic                                     pready,
	output logic                                     pslverr,
	input  wire logic [`GFLM_NUM_UNITS*`GFLM_LOC_W-1:0] err_in,
	input  wire logic                                halt_req_in,
	input  wire logic                                livelock_in,
	output logic                                     halt_out,
	output logic                                     alert_out,
	output logic                                     mcheck_irq,
	output logic                                     syserr_irq,
	output logic                                     accel_irq,
	output logic                                     throttle_main,
	output logic                                     quiesce_flow,
	output logic                                     quiesce_main,
	output logic                                     resolve_mode
);
	localparam int NU = `GFLM_NUM_UNITS;
	localparam int LW = `GFLM_LOC_W;

	// Bus handshake state
	logic          pready_r;
	logic          pslverr_r;
	gflm_word_t    prdata_r;
	gflm_word_t    rd_data;
	logic          rd_err;
	logic          wr_en;
	logic          unit_hit;
	logic [3:0]    unit_idx;
	logic [1:0]    unit_sub;

	// Global registers
	gflm_word_t    halt_status_r;
	gflm_word_t    halt_nxt;
	gflm_word_t    rec_status_r;
	gflm_word_t    att_status_r;
	gflm_word_t    mode_r;
	gflm_word_t    unmask_r;
	logic [NU-1:0] ovf_status_r;
	logic [3:0]    ss_ctrl_r;
	logic [8:0]    llcfg_r;
	logic [LW-1:0] syserr_en_r;
	logic          halted_r;
	logic          alert_r;
	logic          mcheck_r;
	logic          syserr_r;
	logic          accel_r;
	logic          resolve_r;
	gflm_ll_e      ll_state_r;

	// Per-unit local setup and results
	logic [LW-1:0] halt_sel_r [0:NU-1];
	logic [LW-1:0] lmask_r    [0:NU-1];
	logic [LW-1:0] fault      [0:NU-1];
	logic [NU-1:0] halt_sum;
	logic [NU-1:0] rec_sum;
	logic [NU-1:0] ovf_evt;
	logic [NU-1:0] clr_we;
	logic [NU-1:0] halt_raw;
	logic          halt_trig;
	logic          rec_frozen;
	logic          ll_qual;
	logic          ll_flag;
	logic          resample_wr;
	logic          mchk_cond;
	logic          syserr_cond;
	gflm_word_t    serial_rd;

	// ======================================================================
	// APB access decode
	assign wr_en    = psel & penable & pready_r & pwrite;
	assign unit_hit = (paddr[11:8] == `GFLM_UNIT_PAGE) && (paddr[7:4] < 4'(NU));
	assign unit_idx = paddr[7:4];
	assign unit_sub = paddr[3:2];

	// Read mux, unmapped addresses answer with an error and zero data
	always_comb begin
		rd_data = `GFLM_RST_WORD;
		rd_err  = 1'b0;
		if (paddr == `GFLM_OFF_HALT) begin
			rd_data = halt_status_r;
		end else if (paddr == `GFLM_OFF_REC) begin
			rd_data = rec_status_r;
		end else if (paddr == `GFLM_OFF_ATT) begin
			rd_data = att_status_r;
		end else if (paddr == `GFLM_OFF_MODE) begin
			rd_data = mode_r;
		end else if (paddr == `GFLM_OFF_UNMASK) begin
			rd_data = unmask_r;
		end else if (paddr == `GFLM_OFF_OVF) begin
			rd_data = {20'h0_0000, ovf_status_r};
		end else if (paddr == `GFLM_OFF_SERIAL) begin
			rd_data = serial_rd;
		end else if (paddr == `GFLM_OFF_LLCFG) begin
			rd_data = {23'h00_0000, llcfg_r};
		end else if (paddr == `GFLM_OFF_SYSERR) begin
			rd_data = {24'h00_0000, syserr_en_r};
		end else if (unit_hit && unit_sub == 2'h0) begin
			rd_data = {24'h00_0000, fault[unit_idx]};
		end else if (unit_hit && unit_sub == 2'h1) begin
			rd_data = `GFLM_RST_WORD; // Clear port is write-only
		end else if (unit_hit && unit_sub == 2'h2) begin
			rd_data = {24'h00_0000, halt_sel_r[unit_idx]};
		end else if (unit_hit && unit_sub == 2'h3) begin
			rd_data = {24'h00_0000, lmask_r[unit_idx]};
		end else begin
			rd_err = 1'b1;
		end
	end

	// One wait state: ready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= `GFLM_RST_WORD;
		end else if (psel && penable && !pready_r) begin
			pready_r  <= 1'b1;
			pslverr_r <= rd_err;
			prdata_r  <= pwrite ? `GFLM_RST_WORD : rd_data;
		end else begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;

	// ======================================================================
	// Software control registers
	// unmask resets to all zeros, one unmasks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r      <= `GFLM_RST_WORD;
			unmask_r    <= `GFLM_RST_WORD;
			llcfg_r     <= '0;
			syserr_en_r <= `GFLM_RST_BYTE;
		end else if (wr_en && !pslverr_r) begin
			if (paddr == `GFLM_OFF_MODE)
				mode_r <= pwdata;
			else if (paddr == `GFLM_OFF_UNMASK)
				unmask_r <= pwdata;
			else if (paddr == `GFLM_OFF_LLCFG)
				llcfg_r <= pwdata[8:0];
			else if (paddr == `GFLM_OFF_SYSERR)
				syserr_en_r <= pwdata[LW-1:0];
		end
	end

	// Per-unit halt select and local mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NU; i++) begin
				halt_sel_r[i] <= `GFLM_RST_BYTE;
				lmask_r[i]    <= `GFLM_RST_BYTE;
			end
		end else if (wr_en && !pslverr_r && unit_hit) begin
			if (unit_sub == 2'h2)
				halt_sel_r[unit_idx] <= pwdata[LW-1:0];
			else if (unit_sub == 2'h3)
				lmask_r[unit_idx] <= pwdata[LW-1:0];
		end
	end

	// ======================================================================
	// Local units
	genvar g;
	generate
		for (g = 0; g < NU; g++) begin : g_unit
			assign clr_we[g] = wr_en && unit_hit && (unit_idx == 4'(g)) && (unit_sub == 2'h1) && !halted_r;
			gflm_unit_fault #(
				.HAS_CNT (g == `GFLM_U_MEM || g == `GFLM_U_CORE || g >= `GFLM_U_ACC0)
			) u_unit (
				.pclk     (pclk),
				.presetn  (presetn),
				.err_in   (err_in[g*LW +: LW]),
				.clr_we   (clr_we[g]),
				.clr_mask (pwdata[LW-1:0]),
				.stopped  (halted_r),
				.halt_sel (halt_sel_r[g]),
				.lmask    (lmask_r[g]),
				.fault_r  (fault[g]),
				.halt_sum (halt_sum[g]),
				.rec_sum  (rec_sum[g]),
				.ovf_evt  (ovf_evt[g])
			);
		end
	endgenerate

	// ======================================================================
	// Global halt status
	// accelerator halts counted only with mode bit 26
	always_comb begin
		halt_raw = halt_sum;
		for (int i = `GFLM_U_ACC0; i < NU; i++)
			halt_raw[i] = halt_sum[i] & mode_r[`GFLM_MODE_ACCH];
	end

	// unmasked sources, overflow halt, request level
	always_comb begin
		halt_nxt = `GFLM_RST_WORD;
		halt_nxt[NU-1:0] = halt_raw & unmask_r[NU-1:0];
		halt_nxt[`GFLM_HALT_OVF_BIT] = (|ovf_status_r) & mode_r[`GFLM_MODE_OVFH];
		halt_nxt[`GFLM_HALT_REQ_BIT] = halt_req_in;
	end

	// request input halts only when unmask bit 14 set
	assign halt_trig = (|halt_nxt[`GFLM_HALT_OVF_BIT:0]) | (halt_req_in & unmask_r[`GFLM_UM_HALTREQ]);

	// freeze on first halt, held until reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_status_r <= `GFLM_RST_WORD;
			halted_r      <= 1'b0;
		end else if (!halted_r) begin
			halt_status_r <= halt_nxt;
			halted_r      <= halt_trig;
		end
	end

	assign halt_out = halted_r;

	// ======================================================================
	// Global recoverable status
	// mode bit 19 freezes on first recoverable error
	assign rec_frozen = halted_r | (mode_r[`GFLM_MODE_RFRZ] & (|rec_status_r));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rec_status_r <= `GFLM_RST_WORD;
		else if (!rec_frozen)
			rec_status_r <= {20'h0_0000, rec_sum & unmask_r[`GFLM_UM_REC_BASE +: NU]};
	end

	// ======================================================================
	// Counter overflow status, write one to clear, new overflow wins
	// record overflow of any local counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ovf_status_r <= '0;
		else if (wr_en && !pslverr_r && paddr == `GFLM_OFF_OVF)
			ovf_status_r <= (ovf_status_r & ~pwdata[NU-1:0]) | ovf_evt;
		else
			ovf_status_r <= ovf_status_r | ovf_evt;
	end

	// ======================================================================
	// Machine check and system error toward the main core
	// cache machine check with both enables
	assign mchk_cond = fault[`GFLM_U_CACHE][`GFLM_CACHE_MCHK] & ~lmask_r[`GFLM_U_CACHE][`GFLM_CACHE_MCHK]
		& llcfg_r[`GFLM_CFG_CMCHK] & unmask_r[`GFLM_UM_MCHK];
	assign syserr_cond = (|(fault[`GFLM_U_IO] & ~lmask_r[`GFLM_U_IO] & syserr_en_r)) & unmask_r[`GFLM_UM_MCHK];

	// Attention flag is sticky until reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			att_status_r <= `GFLM_RST_WORD;
		else if (mchk_cond || syserr_cond)
			att_status_r[`GFLM_ATT_MCHK] <= 1'b1;
	end

	// Interrupt levels to the main core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mcheck_r <= 1'b0;
			syserr_r <= 1'b0;
			accel_r  <= 1'b0;
		end else begin
			mcheck_r <= mchk_cond;
			syserr_r <= syserr_cond;
			// accelerator halt as interrupt when bit 26 low
			accel_r  <= (|(halt_sum[NU-1:`GFLM_U_ACC0] & unmask_r[NU-1:`GFLM_U_ACC0]))
				& ~mode_r[`GFLM_MODE_ACCH];
		end
	end

	assign mcheck_irq = mcheck_r;
	assign syserr_irq = syserr_r;
	assign accel_irq  = accel_r;

	// ======================================================================
	// Livelock detection and recovery
	// all enables set, both responses clear
	assign ll_qual = livelock_in & (&llcfg_r[3:0]) & ~llcfg_r[4] & ~llcfg_r[5];
	// resample on write of bit 4
	assign resample_wr = wr_en && !pslverr_r && paddr == `GFLM_OFF_SERIAL && pwdata[`GFLM_SS_RESAMPLE];

	// Livelock tracking machine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ll_state_r <= GFLM_LL_IDLE;
		end else if (resample_wr) begin
			ll_state_r <= GFLM_LL_RESAMPLE;
		end else begin
			case (ll_state_r)
				GFLM_LL_IDLE: begin
					if (ll_qual)
						ll_state_r <= GFLM_LL_DETECTED;
				end
				GFLM_LL_DETECTED: begin
					ll_state_r <= GFLM_LL_DETECTED;
				end
				GFLM_LL_RESAMPLE: begin
					ll_state_r <= ll_qual ? GFLM_LL_DETECTED : GFLM_LL_IDLE;
				end
				default: begin
					ll_state_r <= GFLM_LL_IDLE;
				end
			endcase
		end
	end

	assign ll_flag = (ll_state_r == GFLM_LL_DETECTED);

	// Serial control bits: quiesce flow, quiesce main, throttle, resolve
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ss_ctrl_r <= 4'h0;
		else if (wr_en && !pslverr_r && paddr == `GFLM_OFF_SERIAL)
			ss_ctrl_r <= pwdata[`GFLM_SS_RESOLVE:`GFLM_SS_QFLOW];
	end

	// resolution acts only while not throttled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			resolve_r <= 1'b0;
		else
			resolve_r <= ss_ctrl_r[`GFLM_SS_RESOLVE-`GFLM_SS_QFLOW] & ~ss_ctrl_r[`GFLM_SS_THROTTLE-`GFLM_SS_QFLOW];
	end

	assign quiesce_flow  = ss_ctrl_r[`GFLM_SS_QFLOW-`GFLM_SS_QFLOW];
	assign quiesce_main  = ss_ctrl_r[`GFLM_SS_QMAIN-`GFLM_SS_QFLOW];
	assign throttle_main = ss_ctrl_r[`GFLM_SS_THROTTLE-`GFLM_SS_QFLOW];
	assign resolve_mode  = resolve_r;

	// livelock shown in bits 0 and 7
	always_comb begin
		serial_rd = `GFLM_RST_WORD;
		serial_rd[`GFLM_SS_LL_A] = ll_flag;
		serial_rd[`GFLM_SS_LL_B] = ll_flag;
		serial_rd[`GFLM_SS_RESOLVE:`GFLM_SS_QFLOW] = ss_ctrl_r;
	end

	// alert on halt or unresolved livelock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			alert_r <= 1'b0;
		else
			alert_r <= halted_r | halt_trig | ll_flag;
	end

	assign alert_out = alert_r;
endmodule

// >>> bench/gflm_top_props.sv
// Port-level checks for the fault and livelock monitor
`timescale 1ns/100ps
module gflm_top_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic halt_out,
	input wire logic alert_out,
	input wire logic throttle_main,
	input wire logic quiesce_flow,
	input wire logic quiesce_main,
	input wire logic resolve_mode
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ==========================================
	// Bus timing
	sequence s_wait;
		psel && !penable ##1 psel && penable && !pready;
	endsequence
	a_ready_wait: assert property (s_wait |=> pready) else $error("no answer after one wait");
	a_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than a cycle");
	a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
	// ==========================================
	// Halt and alert
	a_halt_hold: assert property (halt_out |=> halt_out) else $error("halt dropped");
	a_halt_alert: assert property (halt_out |-> alert_out) else $error("halt without alert");
	// ==========================================
	// Flow, main and throttle controls move only on a finished write; resolve never follows a throttled cycle
	a_throttle_wr: assert property ($changed(throttle_main) |->
		$past(psel && penable && pready && pwrite)) else $error("throttle moved alone");
	a_qflow_wr: assert property ($changed(quiesce_flow) |->
		$past(psel && penable && pready && pwrite)) else $error("flow quiesce moved alone");
	a_qmain_wr: assert property ($changed(quiesce_main) |->
		$past(psel && penable && pready && pwrite)) else $error("main quiesce moved alone");
	a_resolve_thr: assert property (resolve_mode |-> !$past(throttle_main))
		else $error("resolving while throttled");
endmodule
bind gflm_top gflm_top_props gflm_top_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .halt_out(halt_out),
	.alert_out(alert_out), .throttle_main(throttle_main), .quiesce_flow(quiesce_flow),
	.quiesce_main(quiesce_main), .resolve_mode(resolve_mode));

// >>> bench/gflm_sysctl_model.sv
// System controller model watching alert, raising halt request
`timescale 1ns/100ps
module gflm_sysctl_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic alert_out,
	input  wire logic give_up,
	output logic      halt_req_in,
	output logic      alert_seen
);
	// Halt request only when recovery failed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			halt_req_in <= 1'b0;
		else
			halt_req_in <= give_up;
	end
	// Note the alert before reading status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			alert_seen <= 1'b0;
		else if (alert_out)
			alert_seen <= 1'b1;
	end
endmodule

// >>> bench/global_fault_livelock_monitor_bench.sv
// Self-checking bench for the fault and livelock monitor
`timescale 1ns/100ps
`include "gflm_params.svh"
module global_fault_livelock_monitor_bench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [`GFLM_NUM_UNITS*`GFLM_LOC_W-1:0] err_in;
	logic ll, give_up, halt_req_in, alert_seen, halt_out, alert_out;
	logic mcheck_irq, syserr_irq, accel_irq, throttle_main, quiesce_flow, quiesce_main, resolve_mode;
	int mismatches, compares, cycles;
	gflm_top gflm_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .err_in(err_in), .halt_req_in(halt_req_in), .livelock_in(ll),
		.halt_out(halt_out), .alert_out(alert_out), .mcheck_irq(mcheck_irq), .syserr_irq(syserr_irq),
		.accel_irq(accel_irq), .throttle_main(throttle_main), .quiesce_flow(quiesce_flow),
		.quiesce_main(quiesce_main), .resolve_mode(resolve_mode));
	gflm_sysctl_model gflm_sysctl_model_i (.pclk(pclk), .presetn(presetn), .alert_out(alert_out),
		.give_up(give_up), .halt_req_in(halt_req_in), .alert_seen(alert_seen));
	// ==========================================
	// Shared tasks
	task automatic finish_test;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		compares++;
		if (g !== x) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	// One APB transfer, held until ready is seen
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Take the answer at the rising edge that sees ready high
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Reset in mid-run, driven on the rising edge
	task automatic reboot;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask
	// Pulse one local error bit
	task automatic hit(input int b);
		@(posedge pclk);
		err_in[b] <= 1'b1;
		@(posedge pclk);
		err_in[b] <= 1'b0;
		idle(2);
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reset;
		for (int a = 0; a <= 32; a += 4) begin
			xfer(1'b0, 12'(a), 32'h0);
			chk(q, 32'h0); // Cleared at reset
		end
		xfer(1'b0, 12'h0fc, 32'h0);
		chk(32'(e), 32'h1);
	endtask
	task automatic t_haltreq;
		give_up <= 1'b1;
		idle(3);
		xfer(1'b0, 12'h000, 32'h0);
		chk(q, 32'h1000_0000); // Request level shown
		chk(32'(halt_out), 32'h0); // No halt while bit 14 clear
		give_up <= 1'b0;
	endtask
	task automatic t_livelock;
		xfer(1'b1, 12'h01c, 32'h1f);
		ll <= 1'b1;
		idle(3);
		xfer(1'b0, 12'h018, 32'h0);
		chk(q & 32'h81, 32'h0); // Response control blocks it
		xfer(1'b1, 12'h01c, 32'h0f);
		idle(3);
		xfer(1'b0, 12'h018, 32'h0);
		chk(q & 32'h81, 32'h81); // Both bits set
		chk(32'(alert_out), 32'h1); // Alert raised
		chk(32'(alert_seen), 32'h1); // Controller saw it
		xfer(1'b1, 12'h018, 32'h4_0000);
		xfer(1'b1, 12'h018, 32'hf_0000);
		idle(2);
		chk({throttle_main, quiesce_flow, quiesce_main, resolve_mode}, 32'he); // Throttled
		xfer(1'b1, 12'h018, 32'hb_0000);
		idle(2);
		chk({throttle_main, quiesce_flow, quiesce_main, resolve_mode}, 32'h7); // Resolving
		xfer(1'b1, 12'h018, 32'hb_0010);
		idle(2);
		xfer(1'b0, 12'h018, 32'h0);
		chk(q & 32'h81, 32'h81); // Still stuck
		ll <= 1'b0;
		xfer(1'b1, 12'h018, 32'hb_0010);
		idle(3);
		xfer(1'b0, 12'h018, 32'h0);
		chk(q & 32'h81, 32'h0); // Resolved
		chk(32'(alert_out), 32'h0); // Alert dropped
		xfer(1'b1, 12'h018, 32'h0);
		idle(2);
		chk({quiesce_flow, quiesce_main, resolve_mode}, 32'h0); // Released
	endtask
	task automatic t_ovf;
		xfer(1'b1, 12'h010, 32'h000a_0000);
		for (int i = 0; i < 16; i++) begin
			if (i == 15) begin
				xfer(1'b0, 12'h014, 32'h0);
				chk(q, 32'h0); // No overflow yet at fifteen
			end
			hit(8);
			xfer(1'b1, 12'h114, 32'h1);
		end
		xfer(1'b0, 12'h014, 32'h0);
		chk(q, 32'h2); // Memory counter overflow
	endtask
	task automatic t_rec;
		hit(8);
		xfer(1'b0, 12'h004, 32'h0);
		chk(q, 32'h2); // Unit summary
		xfer(1'b1, 12'h114, 32'h1);
		xfer(1'b0, 12'h110, 32'h0);
		chk(q, 32'h0); // Cleared by write
		xfer(1'b0, 12'h004, 32'h0);
		chk(q, 32'h0); // Tracks current state
		xfer(1'b1, 12'h00c, 32'h8_0000);
		hit(8);
		xfer(1'b1, 12'h114, 32'h1);
		hit(24);
		xfer(1'b0, 12'h004, 32'h0);
		chk(q, 32'h2); // First error froze it
	endtask
	task automatic t_accel;
		xfer(1'b1, 12'h010, 32'h000a_0010);
		xfer(1'b1, 12'h148, 32'h1);
		hit(32);
		chk({accel_irq, halt_out}, 32'h2); // Interrupt, no halt
		xfer(1'b1, 12'h144, 32'h1);
		idle(2);
		chk(32'(accel_irq), 32'h0); // Gone with the fault
	endtask
	task automatic t_mchk;
		xfer(1'b1, 12'h01c, 32'h100);
		xfer(1'b1, 12'h010, 32'h800a_0010);
		hit(22);
		chk(32'(mcheck_irq), 32'h1); // Machine check sent
		xfer(1'b0, 12'h008, 32'h0);
		chk(q, 32'h8000_0000); // Recorded in bit 31
		xfer(1'b1, 12'h124, 32'h40);
		xfer(1'b1, 12'h020, 32'h1);
		hit(0);
		chk({mcheck_irq, syserr_irq}, 32'h1); // System error sent
		xfer(1'b1, 12'h104, 32'h1);
		idle(2);
		chk(32'(syserr_irq), 32'h0); // Gone with the fault
	endtask
	task automatic t_halt;
		xfer(1'b1, 12'h00c, 32'h0808_0000);
		idle(3);
		chk({halt_out, alert_out}, 32'h3); // Overflow halts
		xfer(1'b0, 12'h000, 32'h0);
		chk(q, 32'h1000); // Overflow source bit
		give_up <= 1'b1;
		hit(8);
		xfer(1'b0, 12'h000, 32'h0);
		chk(q, 32'h1000); // Frozen
		xfer(1'b0, 12'h004, 32'h0);
		chk(q, 32'h2); // Frozen
		xfer(1'b0, 12'h110, 32'h0);
		chk(q, 32'h0); // Input ignored once halted
		xfer(1'b1, 12'h134, 32'h1);
		xfer(1'b0, 12'h130, 32'h0);
		chk(q, 32'h1); // Clear refused after halt
	endtask
	task automatic t_accel_halt;
		give_up <= 1'b0;
		reboot;
		chk(32'(halt_out), 32'h0); // Reset clears halt
		xfer(1'b1, 12'h00c, 32'h0400_0000);
		xfer(1'b1, 12'h010, 32'h0000_0010);
		xfer(1'b1, 12'h148, 32'h1);
		hit(32);
		chk({accel_irq, halt_out}, 32'h1); // Real halt with mode bit 26
		xfer(1'b0, 12'h000, 32'h0);
		chk(q, 32'h10); // Accelerator unit bit
	endtask
	task automatic t_reqhalt;
		reboot;
		give_up <= 1'b1;
		xfer(1'b1, 12'h010, 32'h0000_4000);
		idle(3);
		chk({halt_out, alert_out}, 32'h3); // Request halts with bit 14
		xfer(1'b0, 12'h000, 32'h0);
		chk(q, 32'h1000_0000); // Request bit frozen
	endtask
	// ==========================================
	// Clock, timeout and main sequence
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			finish_test;
		end
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		err_in = '0;
		ll = 1'b0;
		give_up = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_haltreq;
		t_livelock;
		t_ovf;
		t_rec;
		t_accel;
		t_mchk;
		t_halt;
		t_accel_halt;
		t_reqhalt;
		finish_test;
	end
endmodule
